// >>> common/eew_pkg.sv
/*
 * Constants shared by the word-alterable EEPROM access port.
 * Assumes a 100 MHz core clock; all pins are sampled synchronously.
 */
`default_nettype none
package eew_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int WORDS = 128;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_CLK_PERIODS = 1024;
    // Status delay before busy shows, in ns (least figure).
    localparam int STATUS_DELAY_NS = 10;
    localparam int STATUS_DELAY_CYC =
        (STATUS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
    localparam logic [CNT_W-1:0] STATUS_DELAY_CNT =
        CNT_W'(STATUS_DELAY_CYC);
    localparam logic [CNT_W-1:0] PROG_PERIOD_CNT =
        CNT_W'(PROG_CLK_PERIODS);

    typedef enum logic [1:0] {
        EEW_IDLE = 2'b00,
        EEW_DELAY = 2'b01,
        EEW_PROG = 2'b10
    } eew_state_t;
endpackage
`default_nettype wire

// >>> hw/eew_port.sv
/*
 * Parallel host port and self-timed programming control of a 128 x 8
 * word-alterable EEPROM, storage array included.
 * Assumes all host pins and the program clock are synchronous to clk_i.
 */
// Behaviour
// [R01] In multiplexed mode the address is captured when the latch strobe falls.
// [R02] Data is captured when the write strobe rises, then busy goes low.
// [R03] With strobes tied, one low pulse captures address then data.
// [R04] Busy stays low for 1024 program clock periods.
// [R05] The program clock must run between 10 and 50 kHz.
// [R06] All inputs are ignored while programming.
// [R07] Multiplexed read drives the latched word until gate or select rises.
// [R08] Separate-mode read needs the address held stable by the host.
// [R09] Strobe pulses must be 175 ns to 100 us long.
// [R10] The host should hold the write strobe high at power-up.
// [R11] The host must avoid write strobe glitches during power-up.
// [R12] All modes are inhibited while power is not good.
// [R13] With select high the data lines float and strobes are ignored.
// [R14] Data is driven only with select and gate low and write high.
// [R15] Busy is low only while reprogramming.
// [R16] Erased words read as all ones.
`timescale 1ns/1ps
`default_nettype none
module eew_port #(
    parameter int ADDR_W = eew_pkg::ADDR_W,
    parameter int DATA_W = eew_pkg::DATA_W,
    parameter int WORDS = eew_pkg::WORDS
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    // Supply monitor
    input wire logic power_good_i,
    // Program timing clock
    input wire logic program_clock_i,
    // Host strobes, active low except the latch strobe
    input wire logic chip_sel_n_i,
    input wire logic out_gate_n_i,
    input wire logic write_n_i,
    input wire logic addr_latch_i,
    // Separate address mode select and address lines
    input wire logic mux_mode_i,
    input wire logic [ADDR_W-1:0] word_select_lines_i,
    // Data bus as three signals
    input wire logic [DATA_W-1:0] byte_lines_i,
    output logic [DATA_W-1:0] byte_lines_o,
    output logic byte_lines_oe_o,
    // Status
    output logic ready_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        eew_pkg::eew_state_t st;
        logic [eew_pkg::CNT_W-1:0] cnt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic we_prev;
        logic ale_prev;
        logic pclk_prev;
        logic [DATA_W-1:0] dout;
        logic oe;
        logic rdy;
    } eew_regs_t;

    eew_regs_t s_r;
    eew_regs_t s_nxt;
    // Cells hold the inverted value so that a cleared array reads erased.
    logic [DATA_W-1:0] mem_r [WORDS];
    logic wr_go;
    logic [ADDR_W-1:0] rd_addr;
    logic we_rise;
    logic we_fall;
    logic ale_fall;
    logic pclk_rise;
    logic sel_ok;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Both countdowns step alike, so a change to one reaches the other.
    function automatic logic [eew_pkg::CNT_W-1:0] count_down(
        input logic [eew_pkg::CNT_W-1:0] cnt
    );
        return cnt - eew_pkg::CNT_ONE;
    endfunction

    function automatic logic count_done(
        input logic [eew_pkg::CNT_W-1:0] cnt
    );
        return cnt == eew_pkg::CNT_ONE;
    endfunction

    // Pins are sampled once per clock; an edge is seen at the first clock that samples the new level.
    function automatic logic rose_now(
        input logic prev,
        input logic cur
    );
        return !prev && cur;
    endfunction

    function automatic logic fell_now(
        input logic prev,
        input logic cur
    );
        return prev && !cur;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        wr_go = 1'b0;
        sel_ok = power_good_i && !chip_sel_n_i; // [R12] [R13]
        we_rise = rose_now(s_r.we_prev, write_n_i);
        we_fall = fell_now(s_r.we_prev, write_n_i);
        ale_fall = fell_now(s_r.ale_prev, addr_latch_i);
        pclk_rise = rose_now(s_r.pclk_prev, program_clock_i);
        s_nxt.we_prev = write_n_i;
        s_nxt.ale_prev = addr_latch_i;
        s_nxt.pclk_prev = program_clock_i;
        // [R08] Separate mode reads straight from the address lines.
        rd_addr = mux_mode_i ? s_r.addr : word_select_lines_i;
        unique case (s_r.st)
            eew_pkg::EEW_IDLE:
            begin
                s_nxt.rdy = 1'b1;
                if (sel_ok && mux_mode_i && ale_fall)
                begin
                    s_nxt.addr = byte_lines_i[ADDR_W-1:0]; // [R01]
                end
                if (sel_ok && !mux_mode_i && we_fall)
                begin
                    s_nxt.addr = word_select_lines_i; // [R03]
                end
                if (sel_ok && we_rise)
                begin
                    s_nxt.data = byte_lines_i; // [R02] [R03]
                    s_nxt.st = eew_pkg::EEW_DELAY;
                    s_nxt.cnt = eew_pkg::STATUS_DELAY_CNT;
                end
            end
            eew_pkg::EEW_DELAY:
            begin
                s_nxt.cnt = count_down(s_r.cnt);
                if (count_done(s_r.cnt))
                begin
                    s_nxt.st = eew_pkg::EEW_PROG;
                    s_nxt.cnt = eew_pkg::PROG_PERIOD_CNT;
                    s_nxt.rdy = 1'b0; // [R02] [R15]
                end
            end
            eew_pkg::EEW_PROG:
            begin
                // [R04] [R06] Only program clock edges matter here.
                if (pclk_rise)
                begin
                    s_nxt.cnt = count_down(s_r.cnt);
                    if (count_done(s_r.cnt))
                    begin
                        wr_go = 1'b1;
                        s_nxt.st = eew_pkg::EEW_IDLE;
                        s_nxt.rdy = 1'b1; // [R15]
                    end
                end
            end
            default:
            begin
                s_nxt.st = eew_pkg::EEW_IDLE;
            end
        endcase
        // [R14] [R07] Drive only in read with no cycle under way.
        s_nxt.oe = sel_ok && !out_gate_n_i && write_n_i
            && s_r.st == eew_pkg::EEW_IDLE;
        // Zero while floating, so the pins never carry a stale byte.
        s_nxt.dout = '0;
        if (s_nxt.oe)
        begin
            s_nxt.dout = ~mem_r[rd_addr]; // [R16]
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_r <= '{st: eew_pkg::EEW_IDLE, cnt: eew_pkg::CNT_ZERO,
                     addr: '0, data: '0, we_prev: 1'b1, ale_prev: 1'b0,
                     pclk_prev: 1'b0, dout: '0, oe: 1'b0, rdy: 1'b1};
        end
        else if (en_i)
        begin
            s_r <= s_nxt;
        end
    end

    // Array is not reset; contents survive like the real cells would.
    // A plain always lets the power-on fill below share the array; the
    // write still lands on the clock edge that ends programming.
    always @(posedge clk_i)
    begin
        if (en_i && wr_go)
        begin
            mem_r[s_r.addr] <= ~s_r.data;
        end
    end

    // Power-on fill: every word starts out erased.
    initial
    begin
        for (int i = 0; i < WORDS; i++)
        begin
            mem_r[i] = ~eew_pkg::ERASED_BYTE;
        end
    end

    assign byte_lines_o = s_r.dout;
    assign byte_lines_oe_o = s_r.oe;
    assign ready_o = s_r.rdy;
endmodule
`default_nettype wire

// >>> tb/eew_port_checker.sv
/* Port assertions for eew_port.
   Assumes en_i held high and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module eew_port_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Watched inputs
    input wire logic power_good_i,
    input wire logic program_clock_i,
    input wire logic chip_sel_n_i,
    input wire logic out_gate_n_i,
    input wire logic write_n_i,
    // Watched outputs
    input wire logic [7:0] byte_lines_o,
    input wire logic byte_lines_oe_o,
    input wire logic ready_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [10:0] pc_cnt_r;
    // Counting here rather than trusting the busy flag keeps the figure honest.
    always_ff @(posedge clk_i or negedge rstn_i)
        if (!rstn_i) pc_cnt_r <= '0;
        else if (ready_o) pc_cnt_r <= '0;
        else if ($rose(program_clock_i)) pc_cnt_r <= pc_cnt_r + 1'b1;
    busy_length_a: assert property ($rose(ready_o) |->
        pc_cnt_r >= 11'd1023 && pc_cnt_r <= 11'd1025) else $error("busy len");
    busy_start_a: assert property ($rose(write_n_i) && !chip_sel_n_i &&
        power_good_i && ready_o |=> ready_o ##1 !ready_o) else $error("start");
    busy_quiet_a: assert property (!ready_o |-> !byte_lines_oe_o)
        else $error("drive while busy");
    no_restart_a: assert property ($rose(ready_o) |-> ready_o [*4])
        else $error("restart");
    power_read_a: assert property (!power_good_i |=> !byte_lines_oe_o)
        else $error("read with power bad");
    power_write_a: assert property ($rose(write_n_i) && !power_good_i &&
        ready_o |=> ready_o [*2]) else $error("write with power bad");
    standby_float_a: assert property (chip_sel_n_i |=> !byte_lines_oe_o)
        else $error("drive in standby");
    gate_float_a: assert property (out_gate_n_i || !write_n_i |=>
        !byte_lines_oe_o) else $error("drive without gate");
    read_drive_a: assert property (!chip_sel_n_i && !out_gate_n_i &&
        write_n_i && power_good_i && ready_o && $past(ready_o) &&
        $past(write_n_i, 2) |=> byte_lines_oe_o) else $error("no drive");
    idle_zero_a: assert property (!byte_lines_oe_o |->
        byte_lines_o == 8'h00) else $error("data while floating");
endmodule
bind eew_port eew_port_checker u_chk (.clk_i, .rstn_i, .power_good_i,
    .program_clock_i, .chip_sel_n_i, .out_gate_n_i, .write_n_i,
    .byte_lines_o, .byte_lines_oe_o, .ready_o);
`default_nettype wire

// >>> tb/eew_host_model.sv
/* Host processor model driving the parallel port.
   Assumes its tasks are called from the bench's main sequence. */
`timescale 1ns/1ps
`default_nettype none
module eew_host_model (
    // Clock and device answers
    input wire logic clk_i,
    input wire logic [7:0] byte_i,
    input wire logic oe_i,
    // Host pins
    output logic prog_clk_o,
    output logic cs_n_o,
    output logic gate_n_o,
    output logic we_n_o,
    output logic ale_o,
    output logic mux_o,
    output logic [6:0] addr_o,
    output logic [7:0] bus_o
);
    logic ale_r;
    assign ale_o = mux_o ? ale_r : we_n_o;
    initial
    begin
        {cs_n_o, gate_n_o, we_n_o} = 3'h7;
        {ale_r, mux_o, addr_o, bus_o, prog_clk_o} = '0;
    end
    // Far above the legal rate, so a program cycle lasts 4096 clocks.
    always #20 prog_clk_o = ~prog_clk_o;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic start(input logic m, input logic [6:0] a);
        tick(1);
        cs_n_o <= 1'b0;
        mux_o <= m;
        addr_o <= a;
        bus_o <= {1'b0, a};
        ale_r <= m;
        tick(18);
        ale_r <= 1'b0;
        tick(5);
    endtask
    task automatic wr(input logic m, input logic [6:0] a, input logic [7:0] d);
        start(m, a);
        bus_o <= d;
        we_n_o <= 1'b0;
        tick(18);
        we_n_o <= 1'b1;
        tick(1);
        cs_n_o <= 1'b1;
        bus_o <= ~d;
    endtask
    task automatic rd(input logic m, input logic [6:0] a, output logic [8:0] r);
        start(m, a);
        bus_o <= ~{1'b0, a};
        gate_n_o <= 1'b0;
        tick(2);
        #1 r = {oe_i, byte_i};
        tick(1);
        gate_n_o <= 1'b1;
        cs_n_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> tb/eew_port_tb_top.sv
/* Self-checking bench for eew_port.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module eew_port_tb_top;
    logic clk_i, rstn_i, pg, pclk, cs_n, gate_n, we_n, ale, mux, oe, rdy;
    logic [6:0] wsel;
    logic [7:0] bus, dout;
    logic [8:0] r;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [16:0] rows [4] = '{17'h1_005A, 17'h0_7FA5, 17'h1_0100, 17'h0_403C};
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    eew_port DUT (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(1'b1),
        .power_good_i(pg), .program_clock_i(pclk), .chip_sel_n_i(cs_n),
        .out_gate_n_i(gate_n), .write_n_i(we_n), .addr_latch_i(ale),
        .mux_mode_i(mux), .word_select_lines_i(wsel), .byte_lines_i(bus),
        .byte_lines_o(dout), .byte_lines_oe_o(oe), .ready_o(rdy));
    eew_host_model u_host (.clk_i(clk_i), .byte_i(dout), .oe_i(oe),
        .prog_clk_o(pclk), .cs_n_o(cs_n), .gate_n_o(gate_n), .we_n_o(we_n),
        .ale_o(ale), .mux_o(mux), .addr_o(wsel), .bus_o(bus));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        while (rdy !== 1'b1 && k < 6000)
        begin
            @(posedge clk_i);
            #1 k++;
        end
        chk({8'h00, rdy}, 9'h001);
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        rstn_i = 1'b0;
        pg = 1'b1;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            u_host.wr(rows[i][16], rows[i][14:8], rows[i][7:0]);
            repeat (3) @(posedge clk_i);
            #1 chk({8'h00, rdy}, 9'h000);
            wait_rdy();
            u_host.rd(rows[i][16], rows[i][14:8], r);
            chk(r, {1'b1, rows[i][7:0]});
            u_host.rd(!rows[i][16], rows[i][14:8], r);
            chk(r, {1'b1, rows[i][7:0]});
        end
        u_host.rd(1'b0, 7'h22, r);
        chk(r, {1'b1, eew_pkg::ERASED_BYTE});
        u_host.wr(1'b1, 7'h10, 8'h11);
        u_host.wr(1'b0, 7'h10, 8'h22);
        u_host.rd(1'b1, 7'h10, r);
        chk(r, 9'h000);
        wait_rdy();
        u_host.rd(1'b1, 7'h10, r);
        chk(r, 9'h111);
        @(posedge clk_i) pg <= 1'b0;
        u_host.wr(1'b1, 7'h11, 8'h33);
        u_host.rd(1'b1, 7'h11, r);
        chk(r, 9'h000);
        @(posedge clk_i) pg <= 1'b1;
        u_host.rd(1'b0, 7'h11, r);
        chk(r, 9'h1FF);
        u_host.wr(1'b0, 7'h12, 8'h44);
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1 chk({7'h00, oe, rdy}, 9'h001);
        @(posedge clk_i) rstn_i <= 1'b1;
        // The cut cycle must leave its word erased and the rest intact.
        u_host.rd(1'b0, 7'h12, r);
        chk(r, {1'b1, eew_pkg::ERASED_BYTE});
        u_host.rd(1'b1, 7'h7F, r);
        chk(r, 9'h1A5);
        end_sim();
    end
endmodule
`default_nettype wire
